// file: scfg_regs.sv
// top: serial interface config, identification and channel page registers
`timescale 1ns/1ps
module scfg_regs #(
  parameter logic [7:0] TYPE_CODE    = 8'h5a, // arbitrary value
  parameter logic [7:0] PROD_ID_LOW  = 8'h12, // arbitrary value
  parameter logic [7:0] PROD_ID_HIGH = 8'h34, // arbitrary value
  parameter logic [3:0] GRADE_CODE   = 4'h1,  // arbitrary value
  parameter logic [3:0] REVISION     = 4'h2   // arbitrary value
) (
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  scfg_pkg::scfg_req_s       req_i,
  output scfg_pkg::scfg_rsp_s       rsp_o,
  output scfg_pkg::scfg_steer_s     steer_o,
  output logic [1:0]                page_o,
  output logic                      low_bit_order_first_o,
  output logic                      address_step_up_o,
  output logic                      serial_out_pin_active_o,
  output logic                      soft_reset_o
);
  import scfg_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic              software_reset_request;
    logic              low_bit_order_first;
    logic              address_step_up;
    logic              serial_out_pin_active;
    logic [1:0]        page;
    logic [3:0]        reset_count;
    scfg_rsp_s         rsp;
    scfg_steer_s       steer;
  } scfg_state_s;

  scfg_state_s state;
  scfg_state_s next_state;
  scfg_steer_s steer_now;
  logic [7:0]  intf_value;

  scfg_page_decode scfg_page_decode_inst (
    .addr_i  (req_i.addr),
    .page_i  (state.page),
    .wr_i    (req_i.wr),
    .steer_o (steer_now)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    intf_value = {state.software_reset_request, state.low_bit_order_first,
                  state.address_step_up, state.serial_out_pin_active,
                  state.serial_out_pin_active, state.address_step_up,
                  state.low_bit_order_first, state.software_reset_request};
    // steering registered with its access, so the channel strobe lines up with the write
    next_state.steer      = steer_now;
    next_state.rsp.rvalid = req_i.rd;
    next_state.rsp.rdata  = 8'h00;
    if (req_i.rd) begin
      case (req_i.addr)
        SCFG_ADDR_INTF:     next_state.rsp.rdata = intf_value;
        SCFG_ADDR_TYPE:     next_state.rsp.rdata = TYPE_CODE;
        SCFG_ADDR_PID_LOW:  next_state.rsp.rdata = PROD_ID_LOW;
        SCFG_ADDR_PID_HIGH: next_state.rsp.rdata = PROD_ID_HIGH;
        SCFG_ADDR_GRADE:    next_state.rsp.rdata = {GRADE_CODE, REVISION};
        SCFG_ADDR_PAGE:     next_state.rsp.rdata = {6'h00, state.page};
        default:            next_state.rsp.rdata = 8'h00;
      endcase
    end
    // soft reset counts down, then drops the request bit by itself
    if (state.reset_count != 4'h0) begin
      next_state.reset_count = state.reset_count - 4'h1;
      if (state.reset_count == 4'h1) begin
        next_state.software_reset_request = 1'b0;
      end
    end
    if (req_i.wr) begin
      case (req_i.addr)
        SCFG_ADDR_INTF: begin
          // mirror bits ignored on write
          next_state.serial_out_pin_active = req_i.wdata[SCFG_BIT_SDO];
          next_state.address_step_up       = req_i.wdata[SCFG_BIT_STEP];
          next_state.low_bit_order_first   = req_i.wdata[SCFG_BIT_ORDER];
          if (req_i.wdata[SCFG_BIT_RESET] && (state.reset_count == 4'h0)) begin
            next_state.software_reset_request = 1'b1;
            next_state.reset_count            = SCFG_SOFT_RESET_LEN;
          end
        end
        SCFG_ADDR_PAGE: next_state.page = req_i.wdata[1:0];
        default: ;
      endcase
    end
    // the internal reset returns interface and page to defaults as it ends
    if (state.reset_count == 4'h1) begin
      next_state.low_bit_order_first   = SCFG_INTF_RESET[SCFG_BIT_ORDER];
      next_state.address_step_up       = SCFG_INTF_RESET[SCFG_BIT_STEP];
      next_state.serial_out_pin_active = SCFG_INTF_RESET[SCFG_BIT_SDO];
      next_state.page                  = SCFG_PAGE_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      // page wakes up addressing both channels
      state                        <= '0;
      state.page                   <= SCFG_PAGE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rsp_o                   = state.rsp;
  assign steer_o                 = state.steer;
  assign page_o                  = state.page;
  assign low_bit_order_first_o   = state.low_bit_order_first;
  assign address_step_up_o       = state.address_step_up;
  assign serial_out_pin_active_o = state.serial_out_pin_active;
  assign soft_reset_o            = state.software_reset_request;

  // ****************************************
  // assertions
  // ****************************************
  reset_start_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && req_i.addr == SCFG_ADDR_INTF && req_i.wdata[0] && !soft_reset_o) |=> soft_reset_o)
    else $error("soft reset did not start");
  reset_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(soft_reset_o) |-> soft_reset_o [*8] ##1 !soft_reset_o)
    else $error("soft reset did not self clear after 8 cycles");
  step_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && req_i.addr == SCFG_ADDR_INTF && !soft_reset_o) |=> address_step_up_o == $past(req_i.wdata[2]))
    else $error("address step bit not stored");
  order_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && req_i.addr == SCFG_ADDR_INTF && !soft_reset_o) |=> low_bit_order_first_o == $past(req_i.wdata[1]))
    else $error("bit order not stored");
  type_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.rd && req_i.addr == SCFG_ADDR_TYPE) |=> rsp_o.rvalid && rsp_o.rdata == TYPE_CODE)
    else $error("type code wrong");
  mirror_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rsp_o.rvalid && $past(req_i.addr) == SCFG_ADDR_INTF |->
      rsp_o.rdata[7:4] == {rsp_o.rdata[0], rsp_o.rdata[1], rsp_o.rdata[2], rsp_o.rdata[3]})
    else $error("mirror nibble mismatch");
  id_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.rd && req_i.addr == SCFG_ADDR_GRADE) |=> rsp_o.rdata == {GRADE_CODE, REVISION})
    else $error("grade and revision wrong");
  page_both_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && page_o == SCFG_PAGE_BOTH && req_i.addr == SCFG_PAGED_B_LO) |=>
      steer_o.ch0_wr && steer_o.ch1_wr && !steer_o.ch_rd_sel)
    else $error("page both not steering both");
  page_one_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && page_o == SCFG_PAGE_CH1 && req_i.addr == SCFG_PAGED_B_LO) |=>
      !steer_o.ch0_wr && steer_o.ch1_wr && steer_o.ch_rd_sel)
    else $error("page one not steering channel one");
  unpaged_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.addr == SCFG_ADDR_INTF) |=> !steer_o.paged)
    else $error("unpaged address marked paged");

  // ****************************************
  // steering, identification and restore checks
  // ****************************************
  // registered ports lag the request by one edge, so every check except reset_restore_a looks one clock on
  zero_page_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && page_o == SCFG_PAGE_CH0 && req_i.addr == SCFG_PAGED_B_LO) |=>
      steer_o.ch0_wr && !steer_o.ch1_wr && !steer_o.ch_rd_sel)
    else $error("page zero not steering channel zero");
  steer_idle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !req_i.wr |=> !steer_o.ch0_wr && !steer_o.ch1_wr)
    else $error("channel write strobe without a write");
  outside_both_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && req_i.addr == SCFG_ADDR_INTF) |=>
      steer_o.ch0_wr && steer_o.ch1_wr && !steer_o.ch_rd_sel)
    else $error("unpaged write not shared by both channels");
  window_edge_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.addr == SCFG_PAGED_D_HI) |=> steer_o.paged)
    else $error("window end not marked paged");
  window_past_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.addr == SCFG_PAGED_D_HI + 12'h001) |=> !steer_o.paged)
    else $error("address past window marked paged");
  page_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.wr && req_i.addr == SCFG_ADDR_PAGE && !soft_reset_o) |=> page_o == $past(req_i.wdata[1:0]))
    else $error("page field not stored");
  id_low_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.rd && req_i.addr == SCFG_ADDR_PID_LOW) |=> rsp_o.rvalid && rsp_o.rdata == PROD_ID_LOW)
    else $error("product id low byte wrong");
  id_high_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (req_i.rd && req_i.addr == SCFG_ADDR_PID_HIGH) |=> rsp_o.rvalid && rsp_o.rdata == PROD_ID_HIGH)
    else $error("product id high byte wrong");
  read_idle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !req_i.rd |=> !rsp_o.rvalid && rsp_o.rdata == 8'h00)
    else $error("read data shown without a read");
  reset_restore_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(soft_reset_o) |-> page_o == SCFG_PAGE_RESET && !address_step_up_o &&
      !low_bit_order_first_o && !serial_out_pin_active_o)
    else $error("soft reset did not restore defaults");

  // ****************************************
  // scenario covers
  // ****************************************
  soft_reset_c: cover property (@(posedge clock_i) disable iff (!resetn_i) $fell(soft_reset_o));
  page_both_c:  cover property (@(posedge clock_i) disable iff (!resetn_i)
    steer_o.paged && steer_o.ch0_wr && steer_o.ch1_wr);
  page_write_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    req_i.wr && req_i.addr == SCFG_ADDR_PAGE);
  paged_ch1_c:  cover property (@(posedge clock_i) disable iff (!resetn_i) steer_o.ch_rd_sel);

endmodule : scfg_regs

// file: scfg_pkg.sv
// package: register map, field positions, reset values and carriers for the config bank
package scfg_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] SCFG_ADDR_INTF      = 12'h000;
  localparam logic [11:0] SCFG_ADDR_TYPE      = 12'h003;
  localparam logic [11:0] SCFG_ADDR_PID_LOW   = 12'h004;
  localparam logic [11:0] SCFG_ADDR_PID_HIGH  = 12'h005;
  localparam logic [11:0] SCFG_ADDR_GRADE     = 12'h006;
  localparam logic [11:0] SCFG_ADDR_PAGE      = 12'h008;

  // paged windows
  localparam logic [11:0] SCFG_PAGED_A_LO     = 12'h013;
  localparam logic [11:0] SCFG_PAGED_A_HI     = 12'h014;
  localparam logic [11:0] SCFG_PAGED_B_LO     = 12'h034;
  localparam logic [11:0] SCFG_PAGED_B_HI     = 12'h03d;
  localparam logic [11:0] SCFG_PAGED_C_LO     = 12'h110;
  localparam logic [11:0] SCFG_PAGED_C_HI     = 12'h124;
  localparam logic [11:0] SCFG_PAGED_D_LO     = 12'h135;
  localparam logic [11:0] SCFG_PAGED_D_HI     = 12'h14c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SCFG_BIT_RESET      = 0;
  localparam int SCFG_BIT_ORDER      = 1;
  localparam int SCFG_BIT_STEP       = 2;
  localparam int SCFG_BIT_SDO        = 3;
  localparam int SCFG_MIRROR_SHIFT   = 4;

  // ****************************************
  // reset values and page codes
  // ****************************************
  localparam logic [7:0] SCFG_INTF_RESET      = 8'h00;
  localparam logic [1:0] SCFG_PAGE_RESET      = 2'h3;
  localparam logic [1:0] SCFG_PAGE_CH0        = 2'h1;
  localparam logic [1:0] SCFG_PAGE_CH1        = 2'h2;
  localparam logic [1:0] SCFG_PAGE_BOTH       = 2'h3;
  // internal soft reset length in clocks
  localparam logic [3:0] SCFG_SOFT_RESET_LEN  = 4'h8;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } scfg_req_s;

  typedef struct packed {
    logic        rvalid;
    logic [7:0]  rdata;
  } scfg_rsp_s;

  typedef struct packed {
    logic       ch0_wr;
    logic       ch1_wr;
    logic       ch_rd_sel;
    logic       paged;
  } scfg_steer_s;

endpackage : scfg_pkg

// file: scfg_page_decode.sv
// page decoder: steers channel-specific accesses by page field and address window
`timescale 1ns/1ps
module scfg_page_decode (
  input  wire logic [11:0]          addr_i,
  input  wire logic [1:0]           page_i,
  input  wire logic                 wr_i,
  output scfg_pkg::scfg_steer_s     steer_o
);
  import scfg_pkg::*;

  logic in_window;

  always_comb begin
    in_window = ((addr_i >= SCFG_PAGED_A_LO) && (addr_i <= SCFG_PAGED_A_HI)) ||
                ((addr_i >= SCFG_PAGED_B_LO) && (addr_i <= SCFG_PAGED_B_HI)) ||
                ((addr_i >= SCFG_PAGED_C_LO) && (addr_i <= SCFG_PAGED_C_HI)) ||
                ((addr_i >= SCFG_PAGED_D_LO) && (addr_i <= SCFG_PAGED_D_HI));
    steer_o.paged     = in_window;
    // outside the windows both channels share one copy, so write both and read zero
    steer_o.ch0_wr    = wr_i && (!in_window || (page_i == SCFG_PAGE_CH0) || (page_i == SCFG_PAGE_BOTH));
    steer_o.ch1_wr    = wr_i && (!in_window || (page_i == SCFG_PAGE_CH1) || (page_i == SCFG_PAGE_BOTH));
    steer_o.ch_rd_sel = in_window && (page_i == SCFG_PAGE_CH1);
  end

endmodule : scfg_page_decode

// file: scfg_host.sv
// host model: single-byte accesses on the request carrier
`timescale 1ns/1ps
module scfg_host (
  input  wire logic           clock_i,
  input  scfg_pkg::scfg_rsp_s rsp_i,
  output scfg_pkg::scfg_req_s req_o
);
  import scfg_pkg::*;

  initial req_o = '0;
  // ************
  // transfer
  // ************
  // released address and data lines carry the inverse so a stale value cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output scfg_rsp_s r);
    @(posedge clock_i);
    req_o <= {w, !w, a, d};
    @(posedge clock_i);
    req_o <= {1'b0, 1'b0, ~a, ~d};
    @(negedge clock_i);
    r = rsp_i;
  endtask : xfer
endmodule : scfg_host

// file: scfg_regs_tb.sv
// testbench for the config, identification and page bank
`timescale 1ns/1ps
module scfg_regs_tb;
  import scfg_pkg::*;
  logic        clock_i;
  logic        resetn_i;
  scfg_req_s   req;
  scfg_rsp_s   rsp;
  scfg_rsp_s   r;
  scfg_steer_s steer;
  logic [1:0]  page;
  logic        lsb;
  logic        step;
  logic        sdo;
  logic        srst;
  int          fails;
  int          comparisons;
  int          cycles;
  int          n;
  // identity codes handed to the bank, so reads are judged against our own values
  localparam logic [7:0] TB_TYPE    = 8'hc3; // arbitrary value
  localparam logic [7:0] TB_ID_LOW  = 8'h6e; // arbitrary value
  localparam logic [7:0] TB_ID_HIGH = 8'hb7; // arbitrary value
  localparam logic [3:0] TB_GRADE   = 4'h9;  // arbitrary value
  localparam logic [3:0] TB_REV     = 4'h5;  // arbitrary value
  // eight window edges, then their eight outer neighbours
  logic [11:0] win [16] = '{12'h013, 12'h014, 12'h034, 12'h03d, 12'h110, 12'h124, 12'h135, 12'h14c,
                            12'h012, 12'h015, 12'h033, 12'h03e, 12'h10f, 12'h125, 12'h134, 12'h14d};

  scfg_regs #(.TYPE_CODE(TB_TYPE), .PROD_ID_LOW(TB_ID_LOW), .PROD_ID_HIGH(TB_ID_HIGH), .GRADE_CODE(TB_GRADE),
    .REVISION(TB_REV)) scfg_regs_inst (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req), .rsp_o(rsp),
    .steer_o(steer), .page_o(page), .low_bit_order_first_o(lsb), .address_step_up_o(step),
    .serial_out_pin_active_o(sdo), .soft_reset_o(srst));
  scfg_host scfg_host_inst (.clock_i(clock_i), .rsp_i(rsp), .req_o(req));

  // ************
  // helpers
  // ************
  task automatic check(input string name, input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    scfg_rsp_s t;
    scfg_host_inst.xfer(1'b1, a, d, t);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
    scfg_host_inst.xfer(1'b0, a, 8'h00, r);
    check(name, {r.rvalid, r.rdata}, {1'b1, exp});
  endtask : rd

  task automatic finish_test;
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      finish_test();
    end
  end

  // ************
  // sequence
  // ************
  initial begin
    resetn_i = 1'b0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(SCFG_ADDR_INTF, SCFG_INTF_RESET, "intf reset");
    rd(SCFG_ADDR_PAGE, 8'h03, "page reset");
    wr(SCFG_ADDR_TYPE, 8'ha5);
    rd(SCFG_ADDR_TYPE, TB_TYPE, "type code");
    rd(SCFG_ADDR_PID_LOW, TB_ID_LOW, "id low");
    rd(SCFG_ADDR_PID_HIGH, TB_ID_HIGH, "id high");
    rd(SCFG_ADDR_GRADE, {TB_GRADE, TB_REV}, "grade rev");
    rd(12'h00a, 8'h00, "unmapped");
    wr(SCFG_ADDR_INTF, 8'h0e);
    check("bit order", lsb, 1'b1);
    check("step up", step, 1'b1);
    check("sdo on", sdo, 1'b1);
    // copies sit bit-reversed in the upper nibble: bit 7 mirrors bit 0
    rd(SCFG_ADDR_INTF, 8'h7e, "mirror");
    wr(SCFG_ADDR_INTF, 8'hf2);
    check("step down", step, 1'b0);
    rd(SCFG_ADDR_INTF, 8'h42, "mirror ro");
    for (int p = 0; p < 4; p++) begin
      wr(SCFG_ADDR_PAGE, 8'(p));
      check("page out", page, 9'(p));
      rd(SCFG_ADDR_PAGE, 8'(p), "page rd");
      wr(SCFG_PAGED_B_LO, 8'h00);
      check("ch0 wr", steer.ch0_wr, p[0]);
      check("ch1 wr", steer.ch1_wr, p[1]);
      rd(SCFG_PAGED_B_LO, 8'h00, "paged rd");
      check("rd sel", steer.ch_rd_sel, p == 2);
    end
    wr(SCFG_ADDR_PAGE, 8'h01);
    foreach (win[i]) begin
      wr(win[i], 8'h00);
      check("paged", steer.paged, i < 8);
      check("ch1 out", steer.ch1_wr, i >= 8);
    end
    wr(SCFG_ADDR_INTF, 8'h01);
    check("soft reset", srst, 1'b1);
    n = 0;
    while (srst === 1'b1 && n < 20) begin
      n++;
      @(negedge clock_i);
    end
    check("reset len", 9'(n), 9'(SCFG_SOFT_RESET_LEN));
    rd(SCFG_ADDR_INTF, 8'h00, "self clear");
    rd(SCFG_ADDR_PAGE, 8'h03, "page restore");
    finish_test();
  end
endmodule : scfg_regs_tb
